// ---- common/tms_pkg.sv ----
// constants for the tap and motion sleep logic
package tms_pkg;
  // register addresses
  localparam logic [7:0] ADDR_TAP_THRESHOLD = 8'h1d;
  localparam logic [7:0] ADDR_TAP_MAX_LENGTH = 8'h21;
  localparam logic [7:0] ADDR_TAP_GAP_TIME = 8'h22;
  localparam logic [7:0] ADDR_SECOND_TAP_WINDOW = 8'h23;
  localparam logic [7:0] ADDR_TAP_AXIS_CONTROL = 8'h2a;
  localparam logic [7:0] ADDR_FIRST_AXIS_STATUS = 8'h2b;
  localparam logic [7:0] ADDR_SLEEP_CONTROL = 8'h2d;
  localparam logic [7:0] ADDR_EVENT_ENABLE = 8'h2e;
  localparam logic [7:0] ADDR_EVENT_PIN_MAP = 8'h2f;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h30;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // event bit positions (enable, pin map, flags)
  localparam int EV_SINGLE = 6;
  localparam int EV_DOUBLE = 5;
  localparam int EV_ACT = 4;
  localparam int EV_INACT = 3;
  localparam logic [7:0] EV_MASK = 8'h78;
  // tap axis control fields
  localparam int TA_SUPPRESS = 3;
  localparam int TA_X = 2;
  localparam int TA_Y = 1;
  localparam int TA_Z = 0;
  // status fields
  localparam int ST_ASLEEP = 3;
  localparam int ST_TAP_X = 2;
  localparam int ST_TAP_Y = 1;
  localparam int ST_TAP_Z = 0;
  // sleep control fields
  localparam int SC_LINK = 5;
  localparam int SC_AUTO_SLEEP = 4;
  localparam int SC_SLEEP = 2;
  // counts of undecimated samples per register step
  localparam int SAMPLES_PER_LEN_STEP = 1;
  localparam int SAMPLES_PER_GAP_STEP = 2;
  localparam int SAMPLES_PER_WIN_STEP = 2;
  localparam int TIMER_W = 12;

  typedef enum logic [2:0] {
    TAP_IDLE = 3'b000,
    TAP_FIRST = 3'b001,
    TAP_GAP = 3'b010,
    TAP_WINDOW = 3'b011,
    TAP_SECOND = 3'b100,
    TAP_HOLD = 3'b101
  } tms_tap_e;
endpackage : tms_pkg

// ---- logic/tms_tap_motion.sv ----
// tap detection, event flags, pin routing and link / auto-sleep sequencing
// What this block does
// - compare tap acceleration against the tap threshold register at 0x1D
// - longest time above threshold for a valid tap comes from register 0x21
// - after first tap, wait the gap time from 0x22 before the window opens
// - window length from 0x23; second tap starts inside, may end after it
// - single-only: flag single tap when signal drops below threshold within length
// - both enabled: single flag waits until double tap confirmed or rejected
// - suppress bit: above-threshold during gap cancels double tap
// - above threshold when window opens rejects the double tap
// - second tap too long rejects double tap at end of length limit
// - single and double detection follow their own enable bits at 0x2E
// - each axis joins tap detection only when its axis enable is set
// - first crossing axis recorded in status 0x2B, overwritten only, never cleared
// - detection runs on undecimated common-rate samples
// - with link set, activity is searched only after inactivity
// - no auto-sleep while an activity flag stays uncleared
// - asleep state shown by a status bit in 0x2B
// - low-power mode keeps data ready and buffer; sleep is not for acquisition
// - sleep, auto-sleep and link: inactivity drops rate, swaps detection to activity
// - activity while asleep restores rate, flags activity, swaps back to inactivity
// - single, double, activity, inactivity flags at D6..D3, cleared on read
// - enabled event goes to pin a when map bit is 0, pin b when 1, ORed
`timescale 1ns/1ps
module tms_tap_motion
  import tms_pkg::*;
#(
  parameter int SAMPLE_W = 16,
  parameter int THR_SHIFT = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic sampleValid,
  input wire logic signed [SAMPLE_W-1:0] accelX,
  input wire logic signed [SAMPLE_W-1:0] accelY,
  input wire logic signed [SAMPLE_W-1:0] accelZ,
  input wire logic activityHit,
  input wire logic inactivityHit,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic eventPinA,
  output logic eventPinB,
  output logic sleepRateSel,
  output logic activityDetEn,
  output logic inactivityDetEn
);

  // magnitude against threshold scaled up to sample units
  function automatic logic overThr(input logic signed [SAMPLE_W-1:0] s,
                                   input logic [7:0] thr);
    logic [SAMPLE_W:0] mag;
    logic [SAMPLE_W+8:0] lim;
    mag = s[SAMPLE_W-1] ? (SAMPLE_W+1)'(-$signed({s[SAMPLE_W-1], s}))
                        : (SAMPLE_W+1)'($signed({s[SAMPLE_W-1], s}));
    lim = (SAMPLE_W+9)'({thr, {THR_SHIFT{1'b0}}});
    overThr = ((SAMPLE_W+9)'(mag) >= lim);
  endfunction : overThr

  // register step to sample count
  function automatic logic [TIMER_W-1:0] steps(input logic [7:0] v, input int per);
    steps = TIMER_W'(32'(v) * per);
  endfunction : steps

  // any pending event steered to the pin chosen by sel
  function automatic logic pinOr(input logic [7:0] pend, input logic [7:0] sel);
    pinOr = |(pend & sel);
  endfunction : pinOr

  // one-hot first axis, x before y before z on a same-sample tie
  function automatic logic [2:0] firstOf(input logic [2:0] over);
    firstOf = over[2] ? 3'b100 : (over[1] ? 3'b010 : 3'b001);
  endfunction : firstOf

  logic [7:0] tapThreshold_r;
  logic [7:0] tapMaxLength_r;
  logic [7:0] tapGapTime_r;
  logic [7:0] secondTapWindow_r;
  logic [7:0] tapAxisControl_r;
  logic [7:0] eventEnable_r;
  logic [7:0] eventPinMap_r;
  logic [7:0] sleepControl_r;
  logic [7:0] eventFlags_r;
  logic [2:0] firstAxis_r;
  logic asleep_r;
  logic actArmed_r;
  logic inactArmed_r;
  tms_tap_e tapState_r;
  logic [TIMER_W-1:0] tapCnt_r;

  logic wrHit;
  logic flagsRead;
  logic [2:0] axisOver;
  logic anyOver;
  logic singleEn;
  logic doubleEn;
  logic doubleUsable;
  logic [TIMER_W-1:0] lenLimit;
  logic [TIMER_W-1:0] gapLimit;
  logic [TIMER_W-1:0] winLimit;
  logic singleEv;
  logic doubleEv;
  logic actEv;
  logic inactEv;
  logic [7:0] evSet;
  logic [7:0] evPending;
  logic linkOn;
  logic autoSleepOn;

  assign wrHit = clkEn && regWrEn;
  assign flagsRead = clkEn && regRdEn && (regAddr == ADDR_EVENT_FLAGS);
  assign linkOn = sleepControl_r[SC_LINK];
  // the drop to sleep needs sleep, auto-sleep and link together
  assign autoSleepOn = linkOn && sleepControl_r[SC_SLEEP]
                       && sleepControl_r[SC_AUTO_SLEEP];

  // axis enables gate the per-axis comparisons
  assign axisOver[2] = tapAxisControl_r[TA_X] && overThr(accelX, tapThreshold_r);
  assign axisOver[1] = tapAxisControl_r[TA_Y] && overThr(accelY, tapThreshold_r);
  assign axisOver[0] = tapAxisControl_r[TA_Z] && overThr(accelZ, tapThreshold_r);
  assign anyOver = |axisOver;

  assign singleEn = eventEnable_r[EV_SINGLE];
  assign doubleEn = eventEnable_r[EV_DOUBLE];
  // zero gap or window leaves double tap dead, as the host is told
  assign doubleUsable = doubleEn && (tapGapTime_r != 8'h00)
                        && (secondTapWindow_r != 8'h00);
  assign lenLimit = steps(tapMaxLength_r, SAMPLES_PER_LEN_STEP);
  assign gapLimit = steps(tapGapTime_r, SAMPLES_PER_GAP_STEP);
  assign winLimit = steps(secondTapWindow_r, SAMPLES_PER_WIN_STEP);

  // register writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      tapThreshold_r <= RST_REG;
      tapMaxLength_r <= RST_REG;
      tapGapTime_r <= RST_REG;
      secondTapWindow_r <= RST_REG;
      tapAxisControl_r <= RST_REG;
      eventEnable_r <= RST_REG;
      eventPinMap_r <= RST_REG;
      sleepControl_r <= RST_REG;
    end else if (wrHit) begin
      unique case (regAddr)
        ADDR_TAP_THRESHOLD: tapThreshold_r <= regWrData;
        ADDR_TAP_MAX_LENGTH: tapMaxLength_r <= regWrData;
        ADDR_TAP_GAP_TIME: tapGapTime_r <= regWrData;
        ADDR_SECOND_TAP_WINDOW: secondTapWindow_r <= regWrData;
        ADDR_TAP_AXIS_CONTROL: tapAxisControl_r <= regWrData & 8'h0f;
        ADDR_EVENT_ENABLE: eventEnable_r <= regWrData & EV_MASK;
        ADDR_EVENT_PIN_MAP: eventPinMap_r <= regWrData & EV_MASK;
        ADDR_SLEEP_CONTROL: sleepControl_r <= regWrData & 8'h34;
        default: ;
      endcase
    end
  end

  // tap sequencer, stepped only by undecimated sample strobes
  always_ff @(posedge mclk) begin
    if (srst) begin
      tapState_r <= TAP_IDLE;
      tapCnt_r <= '0;
      singleEv <= 1'b0;
      doubleEv <= 1'b0;
      firstAxis_r <= 3'b000;
    end else if (clkEn) begin
      singleEv <= 1'b0;
      doubleEv <= 1'b0;
      if (sampleValid) begin
        unique case (tapState_r)
          TAP_IDLE: begin
            if (anyOver && (singleEn || doubleEn)) begin
              firstAxis_r <= firstOf(axisOver);
              tapCnt_r <= TIMER_W'(1);
              tapState_r <= TAP_FIRST;
            end
          end
          TAP_FIRST: begin
            if (anyOver) begin
              if (tapCnt_r >= lenLimit) begin
                tapState_r <= TAP_HOLD;
              end else begin
                tapCnt_r <= tapCnt_r + TIMER_W'(1);
              end
            end else if (doubleUsable) begin
              tapCnt_r <= TIMER_W'(1);
              tapState_r <= TAP_GAP;
            end else begin
              singleEv <= singleEn;
              tapState_r <= TAP_IDLE;
            end
          end
          TAP_GAP: begin
            // gap counts from the sample that ended the first tap
            if (anyOver && tapAxisControl_r[TA_SUPPRESS]) begin
              singleEv <= singleEn;
              tapState_r <= TAP_HOLD;
            end else if (tapCnt_r >= gapLimit) begin
              tapCnt_r <= '0;
              tapState_r <= TAP_WINDOW;
            end else begin
              tapCnt_r <= tapCnt_r + TIMER_W'(1);
            end
          end
          TAP_WINDOW: begin
            if (anyOver && tapCnt_r == '0) begin
              singleEv <= singleEn;
              tapState_r <= TAP_HOLD;
            end else if (anyOver) begin
              tapCnt_r <= TIMER_W'(1);
              tapState_r <= TAP_SECOND;
            end else if (tapCnt_r + TIMER_W'(1) >= winLimit) begin
              singleEv <= singleEn;
              tapState_r <= TAP_IDLE;
            end else begin
              tapCnt_r <= tapCnt_r + TIMER_W'(1);
            end
          end
          TAP_SECOND: begin
            // may run past the window end; only the length limit bounds it
            if (anyOver) begin
              if (tapCnt_r >= lenLimit) begin
                singleEv <= singleEn;
                tapState_r <= TAP_HOLD;
              end else begin
                tapCnt_r <= tapCnt_r + TIMER_W'(1);
              end
            end else begin
              singleEv <= singleEn;
              doubleEv <= 1'b1;
              tapState_r <= TAP_IDLE;
            end
          end
          TAP_HOLD: begin
            // stay put until the spike ends so it cannot start a new tap
            if (!anyOver) begin
              tapState_r <= TAP_IDLE;
            end
          end
          default: tapState_r <= TAP_IDLE;
        endcase
      end
    end
  end

  assign actEv = activityHit && actArmed_r && eventEnable_r[EV_ACT];
  assign inactEv = inactivityHit && inactArmed_r && eventEnable_r[EV_INACT];

  always_comb begin
    evSet = 8'h00;
    evSet[EV_SINGLE] = singleEv && singleEn;
    evSet[EV_DOUBLE] = doubleEv && doubleEn;
    evSet[EV_ACT] = actEv;
    evSet[EV_INACT] = inactEv;
  end

  // read clears, but a new event in the same cycle survives
  always_ff @(posedge mclk) begin
    if (srst) begin
      eventFlags_r <= RST_REG;
    end else if (clkEn) begin
      eventFlags_r <= ((flagsRead ? 8'h00 : eventFlags_r) | evSet) & EV_MASK;
    end
  end

  // link and auto-sleep sequencing
  always_ff @(posedge mclk) begin
    if (srst) begin
      asleep_r <= 1'b0;
      actArmed_r <= 1'b1;
      inactArmed_r <= 1'b1;
    end else if (clkEn) begin
      if (!linkOn) begin
        actArmed_r <= 1'b1;
        inactArmed_r <= 1'b1;
        asleep_r <= 1'b0;
      end else if (actEv) begin
        actArmed_r <= 1'b0;
        inactArmed_r <= 1'b1;
        asleep_r <= 1'b0;
      end else if (inactEv) begin
        inactArmed_r <= 1'b0;
        actArmed_r <= 1'b1;
        // a pending activity flag blocks the drop to sleep
        if (autoSleepOn && !eventFlags_r[EV_ACT]) begin
          asleep_r <= 1'b1;
        end
      end else if (actArmed_r && inactArmed_r) begin
        actArmed_r <= 1'b0;
      end
    end
  end

  // a flag left over from a disabled event stays off the pins
  assign evPending = eventFlags_r & eventEnable_r;

  // outputs all from flops
  always_ff @(posedge mclk) begin
    if (srst) begin
      eventPinA <= 1'b0;
      eventPinB <= 1'b0;
      sleepRateSel <= 1'b0;
      activityDetEn <= 1'b1;
      inactivityDetEn <= 1'b1;
    end else if (clkEn) begin
      eventPinA <= pinOr(evPending, ~eventPinMap_r);
      eventPinB <= pinOr(evPending, eventPinMap_r);
      // rate drops only through the auto-sleep swap, so waking restores it
      // even with the sleep bit still set; low-power mode is not handled here
      sleepRateSel <= asleep_r;
      activityDetEn <= actArmed_r;
      inactivityDetEn <= inactArmed_r;
    end
  end

  // register reads, one cycle latency
  always_ff @(posedge mclk) begin
    if (srst) begin
      regRdData <= 8'h00;
    end else if (clkEn && regRdEn) begin
      unique case (regAddr)
        ADDR_TAP_THRESHOLD: regRdData <= tapThreshold_r;
        ADDR_TAP_MAX_LENGTH: regRdData <= tapMaxLength_r;
        ADDR_TAP_GAP_TIME: regRdData <= tapGapTime_r;
        ADDR_SECOND_TAP_WINDOW: regRdData <= secondTapWindow_r;
        ADDR_TAP_AXIS_CONTROL: regRdData <= tapAxisControl_r;
        ADDR_FIRST_AXIS_STATUS: regRdData <= {4'h0, asleep_r, firstAxis_r};
        ADDR_SLEEP_CONTROL: regRdData <= sleepControl_r;
        ADDR_EVENT_ENABLE: regRdData <= eventEnable_r;
        ADDR_EVENT_PIN_MAP: regRdData <= eventPinMap_r;
        ADDR_EVENT_FLAGS: regRdData <= eventFlags_r;
        default: regRdData <= 8'h00;
      endcase
    end
  end

endmodule : tms_tap_motion

// ---- sim/tms_tap_motion_assertions.sv ----
// port-level checks for the tap and motion sleep logic
`timescale 1ns/1ps
module tms_tap_motion_assertions
  import tms_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic sampleValid,
  input wire logic activityHit,
  input wire logic inactivityHit,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic eventPinA,
  input wire logic eventPinB,
  input wire logic sleepRateSel,
  input wire logic activityDetEn,
  input wire logic inactivityDetEn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // no sample or hit near the read, so nothing can set a flag again
  sequence quiet_s;
    !sampleValid && !activityHit && !inactivityHit;
  endsequence
  sequence flag_read_s;
    quiet_s [*4] ##0 (clkEn && regRdEn && regAddr == ADDR_EVENT_FLAGS) ##1 quiet_s;
  endsequence
  a_reset_state: assert property (disable iff (1'b0) srst |=> activityDetEn
    && inactivityDetEn && !sleepRateSel && !eventPinA && !eventPinB)
    else $error("state after reset wrong");
  a_read_clears: assert property (flag_read_s |=> !eventPinA && !eventPinB)
    else $error("pins still high after flag read");
  a_sleep_entry: assert property ($rose(sleepRateSel) |->
    $past(inactivityDetEn) && !inactivityDetEn) else $error("sleep entered wrongly");
  a_sleep_arms: assert property (sleepRateSel |-> activityDetEn && !inactivityDetEn)
    else $error("wrong detector armed while asleep");
  a_wake_rearm: assert property ($fell(sleepRateSel) && !$past(srst) &&
    !$past(regWrEn) && !$past(regWrEn, 2) |-> inactivityDetEn && !activityDetEn)
    else $error("wake did not swap detectors");
  a_one_armed: assert property (activityDetEn || inactivityDetEn)
    else $error("no detector armed");
  a_freeze_hold: assert property (!clkEn |=> $stable(eventPinA) && $stable(eventPinB)
    && $stable(sleepRateSel) && $stable(activityDetEn)) else $error("state moved while frozen");
  a_read_hold: assert property (!(clkEn && regRdEn) |=> $stable(regRdData))
    else $error("read data changed without a read");
endmodule : tms_tap_motion_assertions

bind tms_tap_motion tms_tap_motion_assertions i_chk (.mclk(mclk), .srst(srst), .clkEn(clkEn),
  .sampleValid(sampleValid), .activityHit(activityHit), .inactivityHit(inactivityHit),
  .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .eventPinA(eventPinA), .eventPinB(eventPinB), .sleepRateSel(sleepRateSel),
  .activityDetEn(activityDetEn), .inactivityDetEn(inactivityDetEn));

// ---- sim/tms_host.sv ----
// host model: register writes and reads on the falling edge
`timescale 1ns/1ps
module tms_host
  import tms_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn
);
  initial begin
    regAddr = 8'hff;
    regWrData = 8'hff;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  // idle bus shows the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge mclk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge mclk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask : rd
  task automatic setup_tap(input logic [7:0] axes, input logic [7:0] en, input logic [7:0] map);
    wr(ADDR_TAP_THRESHOLD, 8'h31);
    wr(ADDR_TAP_MAX_LENGTH, 8'h11);
    wr(ADDR_TAP_GAP_TIME, 8'h11);
    wr(ADDR_SECOND_TAP_WINDOW, 8'h41);
    wr(ADDR_TAP_AXIS_CONTROL, axes);
    wr(ADDR_EVENT_PIN_MAP, map);
    wr(ADDR_EVENT_ENABLE, en);
  endtask : setup_tap
endmodule : tms_host

// ---- sim/tb.sv ----
// self-checking bench for the tap and motion sleep logic
`timescale 1ns/1ps
module tb
  import tms_pkg::*;
();
  localparam logic signed [15:0] HI = 16'sh0400;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic clkEn = 1'b1;
  logic sampleValid = 1'b0;
  logic signed [15:0] accelX = 16'sh0000;
  logic signed [15:0] accelY = 16'sh0000;
  logic signed [15:0] accelZ = 16'shfc00; // z stays high but is never enabled
  logic activityHit = 1'b0;
  logic inactivityHit = 1'b0;
  logic [7:0] regAddr, regWrData, regRdData, rdv;
  logic regWrEn, regRdEn, eventPinA, eventPinB, sleepRateSel, activityDetEn, inactivityDetEn;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #2.5 mclk = ~mclk;
  tms_host i_host (.mclk(mclk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn));
  tms_tap_motion i_dut (.mclk(mclk), .srst(srst), .clkEn(clkEn), .sampleValid(sampleValid),
    .accelX(accelX), .accelY(accelY), .accelZ(accelZ), .activityHit(activityHit),
    .inactivityHit(inactivityHit), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .eventPinA(eventPinA),
    .eventPinB(eventPinB), .sleepRateSel(sleepRateSel), .activityDetEn(activityDetEn),
    .inactivityDetEn(inactivityDetEn));
  task automatic summarize();
    $display("errors %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // timers count samples, so a spare idle cycle between samples must not matter
  task automatic run(input int n, input logic signed [15:0] x, input logic signed [15:0] y);
    repeat (n) begin
      @(negedge mclk);
      accelX = x;
      accelY = y;
      sampleValid = 1'b1;
      @(negedge mclk);
      sampleValid = 1'b0;
    end
  endtask : run
  task automatic chk_flags(input logic [7:0] pins, input logic [7:0] flags);
    run(2, 16'sh0000, 16'sh0000);
    repeat (4) @(negedge mclk);
    cmp({6'h00, eventPinB, eventPinA}, pins);
    i_host.rd(ADDR_EVENT_FLAGS, rdv);
    cmp(rdv, flags);
  endtask : chk_flags
  task automatic hit(input logic act);
    @(negedge mclk);
    activityHit = act;
    inactivityHit = !act;
    @(negedge mclk);
    activityHit = 1'b0;
    inactivityHit = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : hit
  task automatic t_regs();
    logic [7:0] adr [9] = '{ADDR_TAP_THRESHOLD, ADDR_TAP_MAX_LENGTH, ADDR_TAP_GAP_TIME,
      ADDR_SECOND_TAP_WINDOW, ADDR_TAP_AXIS_CONTROL, ADDR_EVENT_ENABLE, ADDR_EVENT_FLAGS,
      ADDR_FIRST_AXIS_STATUS, 8'h00};
    cmp({5'h00, activityDetEn, inactivityDetEn, sleepRateSel}, 8'h06);
    foreach (adr[k]) begin
      i_host.rd(adr[k], rdv);
      cmp(rdv, 8'h00);
    end
    for (int k = 0; k < 4; k++) begin
      i_host.wr(adr[k], 8'h07);
      i_host.rd(adr[k], rdv);
      cmp(rdv, 8'h07);
    end
    i_host.wr(ADDR_FIRST_AXIS_STATUS, 8'h0f);
    i_host.rd(ADDR_FIRST_AXIS_STATUS, rdv);
    cmp(rdv, 8'h00);
    i_host.wr(8'h00, 8'h5a);
    i_host.rd(8'h00, rdv);
    cmp(rdv, 8'h00);
  endtask : t_regs
  task automatic t_single();
    i_host.setup_tap(8'h04, 8'h40, 8'h00);
    run(3, HI, 16'sh0000);
    chk_flags(8'h01, 8'h40);
    i_host.rd(ADDR_FIRST_AXIS_STATUS, rdv);
    cmp(rdv, 8'h04);
    chk_flags(8'h00, 8'h00);
    run(20, HI, 16'sh0000);
    chk_flags(8'h00, 8'h00);
    run(3, 16'sh0000, HI);
    chk_flags(8'h00, 8'h00);
    i_host.wr(ADDR_TAP_AXIS_CONTROL, 8'h02);
    run(3, 16'sh0000, -HI);
    chk_flags(8'h01, 8'h40);
    i_host.rd(ADDR_FIRST_AXIS_STATUS, rdv);
    cmp(rdv, 8'h02);
  endtask : t_single
  task automatic t_double();
    i_host.setup_tap(8'h04, 8'h60, 8'h20);
    run(3, HI, 16'sh0000);
    run(10, 16'sh0000, 16'sh0000);
    cmp({6'h00, eventPinB, eventPinA}, 8'h00);
    run(30, 16'sh0000, 16'sh0000);
    run(3, HI, 16'sh0000);
    chk_flags(8'h03, 8'h60);
  endtask : t_double
  task automatic t_reject();
    i_host.wr(ADDR_TAP_AXIS_CONTROL, 8'h0c);
    run(3, HI, 16'sh0000);
    run(1, 16'sh0000, 16'sh0000);
    run(2, HI, 16'sh0000);
    run(200, 16'sh0000, 16'sh0000);
    chk_flags(8'h01, 8'h40);
    i_host.wr(ADDR_TAP_AXIS_CONTROL, 8'h04);
    run(3, HI, 16'sh0000);
    run(1, 16'sh0000, 16'sh0000);
    run(60, HI, 16'sh0000);
    run(5, 16'sh0000, 16'sh0000);
    chk_flags(8'h01, 8'h40);
    run(3, HI, 16'sh0000);
    run(40, 16'sh0000, 16'sh0000);
    run(20, HI, 16'sh0000);
    run(200, 16'sh0000, 16'sh0000);
    chk_flags(8'h01, 8'h40);
  endtask : t_reject
  task automatic t_sleep();
    i_host.wr(ADDR_EVENT_ENABLE, 8'h18);
    i_host.wr(ADDR_SLEEP_CONTROL, 8'h34);
    hit(1'b0);
    cmp({5'h00, activityDetEn, inactivityDetEn, sleepRateSel}, 8'h05);
    i_host.rd(ADDR_FIRST_AXIS_STATUS, rdv);
    cmp(rdv & 8'h08, 8'h08);
    clkEn = 1'b0;
    hit(1'b1);
    clkEn = 1'b1;
    cmp({5'h00, activityDetEn, inactivityDetEn, sleepRateSel}, 8'h05);
    i_host.rd(ADDR_EVENT_FLAGS, rdv);
    cmp(rdv, 8'h08);
    hit(1'b1);
    cmp({5'h00, activityDetEn, inactivityDetEn, sleepRateSel}, 8'h02);
    i_host.rd(ADDR_FIRST_AXIS_STATUS, rdv);
    cmp(rdv & 8'h08, 8'h00);
    hit(1'b1);
    hit(1'b0);
    cmp({5'h00, activityDetEn, inactivityDetEn, sleepRateSel}, 8'h04);
    i_host.rd(ADDR_EVENT_FLAGS, rdv);
    cmp(rdv, 8'h18);
  endtask : t_sleep
  initial begin
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    t_regs();
    t_single();
    t_double();
    t_reject();
    t_sleep();
    summarize();
  end
endmodule : tb
